// >>> src/bbcc_codec.sv
/*
 Backplane bus cycle codec: issues command cycles and data cycles as
 commander, and checks command parity, register-data parity and memory ECC
 as receiver. Outgoing memory data passes through a 16-word FIFO.
 Assumes arbitration outside grants issue_go in a legal command cycle and
 drives data_go at the data cycle positions; all inputs are synchronous.
*/
`timescale 1ns/1ps
module bbcc_codec
   import bbcc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Node configuration
   input wire logic [3:0] node_id,
   input wire logic ecc_check_skip,
   // Command issue request
   input wire logic issue_go,
   input wire logic [2:0] issue_cmd,
   input wire logic [34:0] issue_addr,
   // Outgoing data source
   input wire logic [127:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic data_go,
   input wire logic stall_in,
   // Bus outputs
   output logic command_flag,
   output logic confirm_line,
   output logic [3:0] req_out,
   output logic [127:0] bus_d_out,
   output logic [127:0] bus_d_oe,
   output logic [27:0] bus_ecc_out,
   output logic [27:0] bus_ecc_oe,
   output logic err_out,
   // Bus inputs
   input wire logic command_flag_in,
   input wire logic [127:0] bus_d_in,
   input wire logic [27:0] bus_ecc_in,
   input wire logic rx_data_cycle,
   input wire logic rx_is_csr,
   input wire logic [1:0] rx_cycle_num,
   // Receive results and busy flag
   output logic cmd_valid,
   output logic [2:0] cmd_code,
   output logic [34:0] cmd_addr,
   output logic cmd_private,
   output logic rx_ecc_error,
   output logic rx_csr_error,
   output logic busy
);
   typedef enum logic [1:0] {
      BBCC_ST_IDLE = 2'b00,
      BBCC_ST_GAP = 2'b01,
      BBCC_ST_DATA = 2'b10
   } bbcc_state_t;

   bbcc_state_t state_reg;
   logic [3:0] gap_reg;
   logic [1:0] cyc_reg;
   logic [2:0] cur_cmd_reg;
   logic [1:0] stall_pipe_reg;
   logic [2:0] err_hold_reg;
   logic [127:0] tx_word;
   logic tx_word_valid;
   logic tx_word_take;
   logic [27:0] tx_chk;
   logic [27:0] rx_chk;
   logic dead_cycle;
   logic is_csr_cur;
   logic cmd_par_ok;
   logic csr_par_ok;
   logic [37:0] cmd_body;
   logic cmd_detect;
   logic csr_check;
   logic mem_check;
   logic mem_bad;

   bbcc_fifo_if tx_if ();

   assign tx_if.data = tx_data;
   assign tx_if.valid = tx_valid;
   assign tx_ready = tx_if.ready;

   bbcc_fifo #(
      .WIDTH(BBCC_FIFO_W),
      .DEPTH(BBCC_FIFO_D)
   ) u_tx_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_data(tx_if.data),
      .in_valid(tx_if.valid),
      .in_ready(tx_if.ready),
      .out_data(tx_word),
      .out_valid(tx_word_valid),
      .out_ready(tx_word_take)
   );

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lw
         bbcc_ecc u_tx_ecc (
            .lw(tx_word[g*BBCC_LW_W +: BBCC_LW_W]),
            .cyc(cyc_reg),
            .chk(tx_chk[g*BBCC_CHK_W +: BBCC_CHK_W])
         );
         bbcc_ecc u_rx_ecc (
            .lw(bus_d_in[g*BBCC_LW_W +: BBCC_LW_W]),
            .cyc(rx_cycle_num),
            .chk(rx_chk[g*BBCC_CHK_W +: BBCC_CHK_W])
         );
      end
   endgenerate

   // odd parity over the command word
   assign cmd_body = {issue_cmd, issue_addr};
   assign is_csr_cur = (cur_cmd_reg == BBCC_CMD_CSR_RD) || (cur_cmd_reg == BBCC_CMD_CSR_WR);
   // dead cycle two cycles after stall
   assign dead_cycle = stall_pipe_reg[1];
   // no FIFO word consumed in stalled cycles
   assign tx_word_take = (state_reg == BBCC_ST_DATA) && data_go && !dead_cycle
      && !is_csr_cur && (cur_cmd_reg != BBCC_CMD_PRIVATE) && tx_word_valid;

   assign cmd_par_ok = ^bus_d_in[BBCC_CMD_PAR_BIT:0];
   assign cmd_detect = command_flag_in;
   assign csr_par_ok = ^bus_d_in[BBCC_CMD_PAR_BIT:0];
   assign csr_check = rx_data_cycle && rx_is_csr && (rx_cycle_num == 2'b00);
   // check unless bound for same-code memory
   assign mem_check = rx_data_cycle && !rx_is_csr && !ecc_check_skip;
   assign mem_bad = (rx_chk != bus_ecc_in);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stall_pipe_reg <= '0;
      end else begin
         stall_pipe_reg <= {stall_pipe_reg[0], stall_in};
      end
   end

   // command, gap of ten, four data cycles
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= BBCC_ST_IDLE;
         gap_reg <= '0;
         cyc_reg <= '0;
         cur_cmd_reg <= BBCC_CMD_READ;
      end else begin
         case (state_reg)
            BBCC_ST_IDLE: begin
               if (issue_go) begin
                  state_reg <= BBCC_ST_GAP;
                  gap_reg <= '0;
                  cyc_reg <= '0;
                  cur_cmd_reg <= issue_cmd;
               end
            end
            BBCC_ST_GAP: begin
               if (gap_reg != 4'(BBCC_MIN_GAP - 1)) begin
                  gap_reg <= gap_reg + 4'h1;
               end else begin
                  state_reg <= BBCC_ST_DATA;
               end
            end
            BBCC_ST_DATA: begin
               if (data_go && !dead_cycle) begin
                  cyc_reg <= cyc_reg + 2'h1;
                  if (cyc_reg == 2'(BBCC_DATA_CYCLES - 1)) begin
                     state_reg <= BBCC_ST_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= BBCC_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         command_flag <= 1'b0;
         req_out <= '0;
         confirm_line <= 1'b0;
         bus_d_out <= '0;
         bus_d_oe <= '0;
         bus_ecc_out <= '0;
         bus_ecc_oe <= '0;
      end else begin
         command_flag <= 1'b0;
         req_out <= '0;
         confirm_line <= 1'b0;
         bus_d_oe <= '0;
         bus_ecc_oe <= '0;
         bus_d_out <= '0;
         bus_ecc_out <= '0;
         if (state_reg == BBCC_ST_IDLE && issue_go) begin
            command_flag <= 1'b1;
            req_out <= node_id;
            // block address on lines 34..1; wrap on line 0
            // register commands carry the longword address unchanged
            bus_d_out[BBCC_BLK_HI:BBCC_WRAP_BIT] <= issue_addr;
            bus_d_out[BBCC_CMD_HI:BBCC_CMD_LO] <= issue_cmd;
            bus_d_out[BBCC_CMD_PAR_BIT] <= ~(^cmd_body);
            bus_d_oe[BBCC_CMD_PAR_BIT:0] <= '1;
         end
         if (state_reg == BBCC_ST_GAP && gap_reg == 4'h2 && cur_cmd_reg == BBCC_CMD_PRIVATE) begin
            confirm_line <= 1'b1;
         end
         if (state_reg == BBCC_ST_DATA && data_go) begin
            if (is_csr_cur) begin
               // only the first register data cycle is driven
               if (cyc_reg == 2'b00) begin
                  bus_d_oe[BBCC_CMD_PAR_BIT:0] <= '1;
                  bus_d_out[BBCC_CSR_DATA_HI:0] <= tx_data[BBCC_CSR_DATA_HI:0];
                  // odd parity; bad parity when stalled
                  bus_d_out[BBCC_CMD_PAR_BIT] <= (~(^tx_data[BBCC_CSR_DATA_HI:0])) ^ dead_cycle;
               end
            end else if (cur_cmd_reg != BBCC_CMD_PRIVATE) begin
               bus_d_oe <= '1;
               bus_ecc_oe <= '1;
               bus_d_out <= tx_word;
               bus_ecc_out <= tx_chk;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_valid <= 1'b0;
         cmd_code <= BBCC_CMD_READ;
         cmd_addr <= '0;
         cmd_private <= 1'b0;
      end else begin
         cmd_valid <= cmd_detect && cmd_par_ok;
         cmd_private <= cmd_detect && cmd_par_ok
            && (bus_d_in[BBCC_CMD_HI:BBCC_CMD_LO] == BBCC_CMD_PRIVATE);
         if (cmd_detect && cmd_par_ok) begin
            cmd_code <= bus_d_in[BBCC_CMD_HI:BBCC_CMD_LO];
            cmd_addr <= bus_d_in[BBCC_BLK_HI:BBCC_WRAP_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_ecc_error <= 1'b0;
         rx_csr_error <= 1'b0;
         err_hold_reg <= '0;
         err_out <= 1'b0;
      end else begin
         rx_ecc_error <= mem_check && mem_bad;
         rx_csr_error <= csr_check && !csr_par_ok;
         // error line one cycle after fault, held four
         if ((cmd_detect && !cmd_par_ok) || (csr_check && !csr_par_ok)) begin
            err_out <= 1'b1;
            err_hold_reg <= 3'(BBCC_ERR_LIMIT - 1);
         end else if (err_hold_reg != '0) begin
            err_hold_reg <= err_hold_reg - 3'h1;
         end else begin
            err_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
      end else begin
         busy <= (state_reg != BBCC_ST_IDLE) || issue_go;
      end
   end
endmodule

// >>> src/bbcc_pkg.sv
/*
 Package for the backplane bus cycle codec: command codes, field positions,
 timing counts and the check-bit code matrix.
 Assumes a single bus clock shared by every node.
*/
package bbcc_pkg;
   localparam int BBCC_DATA_W = 128;
   localparam int BBCC_ECC_W = 28;
   localparam int BBCC_ID_W = 4;
   localparam int BBCC_FIFO_W = 128;
   localparam int BBCC_FIFO_D = 16;
   localparam int BBCC_CMD_PAR_BIT = 38;
   localparam int BBCC_CMD_LO = 35;
   localparam int BBCC_CMD_HI = 37;
   localparam int BBCC_BLK_LO = 1;
   localparam int BBCC_BLK_HI = 34;
   localparam int BBCC_WRAP_BIT = 0;
   localparam int BBCC_CSR_DATA_HI = 37;
   localparam int BBCC_LW_W = 32;
   localparam int BBCC_CHK_W = 7;
   localparam int BBCC_DATA_CYCLES = 4;
   localparam int BBCC_MIN_GAP = 10;
   localparam int BBCC_ERR_LIMIT = 4;
   localparam int BBCC_STALL_DELAY = 2;
   localparam logic [6:0] BBCC_CHK_INVERT = 7'h0C;

   typedef enum logic [2:0] {
      BBCC_CMD_READ = 3'h0,
      BBCC_CMD_WRITE = 3'h1,
      BBCC_CMD_RSVD2 = 3'h2,
      BBCC_CMD_VICTIM = 3'h3,
      BBCC_CMD_CSR_RD = 3'h4,
      BBCC_CMD_CSR_WR = 3'h5,
      BBCC_CMD_RSVD6 = 3'h6,
      BBCC_CMD_PRIVATE = 3'h7
   } bbcc_cmd_t;

   // Columns per check bit: data bits 31..0 then cycle count bits 1..0
   localparam logic [33:0] BBCC_MATRIX [0:6] = '{
      34'h0000000FF,
      34'h00FFFF003,
      34'h3C0FC0FC3,
      34'h0F03F03F3,
      34'h33330CCCC,
      34'h2CD2B54D5,
      34'h1A6D4AB36
   };
endpackage

// >>> src/bbcc_fifo_if.sv
/*
 Interface carrying one valid/ready word stream inside the codec.
 Assumes producer and consumer share the bus clock.
*/
`timescale 1ns/1ps
interface bbcc_fifo_if;
   logic [127:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// >>> src/bbcc_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module bbcc_fifo #(
   parameter int WIDTH = 128,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Filling side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Draining side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic do_wr;
   logic do_rd;

   assign in_ready = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (do_wr) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count_reg <= count_reg + 1'b1;
         end else if (do_rd && !do_wr) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// >>> src/bbcc_ecc.sv
/*
 Check-bit generator for one 32-bit longword plus the two cycle count bits.
 Pure combinational; assumes the matrix in the package.
*/
`timescale 1ns/1ps
module bbcc_ecc
   import bbcc_pkg::*;
(
   // Longword and cycle count
   input wire logic [31:0] lw,
   input wire logic [1:0] cyc,
   // Check field
   output logic [6:0] chk
);
   logic [33:0] vec;
   assign vec = {lw, cyc};
   always_comb begin
      chk = '0;
      for (int i = 0; i < BBCC_CHK_W; i++) begin
         chk[i] = ^(vec & BBCC_MATRIX[i]);
      end
      chk = chk ^ BBCC_CHK_INVERT;
   end
endmodule

// >>> verif/bbcc_codec_asserts.sv
/*
 Port checker for the bus cycle codec.
 Assumes one bus clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module bbcc_codec_asserts
   import bbcc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Inputs
   input wire logic [3:0] node_id,
   input wire logic issue_go,
   input wire logic [2:0] issue_cmd,
   input wire logic [34:0] issue_addr,
   input wire logic command_flag_in,
   input wire logic [127:0] bus_d_in,
   input wire logic rx_data_cycle,
   input wire logic rx_is_csr,
   input wire logic [1:0] rx_cycle_num,
   // Outputs
   input wire logic command_flag,
   input wire logic confirm_line,
   input wire logic [3:0] req_out,
   input wire logic [127:0] bus_d_out,
   input wire logic [127:0] bus_d_oe,
   input wire logic [27:0] bus_ecc_oe,
   input wire logic err_out,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic [34:0] cmd_addr,
   input wire logic busy
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   sequence s_take;
      issue_go && !busy;
   endsequence
   sequence s_priv;
      command_flag && bus_d_out[37:35] == 3'h7;
   endsequence
   sequence s_rx_bad;
      command_flag_in && !(^bus_d_in[38:0]);
   endsequence
   a_cmd_take: assert property (
      s_take |=> command_flag && bus_d_out[37:0] == $past({issue_cmd, issue_addr}))
      else $error("command word");
   a_cmd_id: assert property (command_flag |-> req_out == $past(node_id))
      else $error("node id");
   a_cmd_parity: assert property (
      command_flag |-> (^bus_d_out[38:0]) && (&bus_d_oe[38:0]))
      else $error("command parity");
   a_gap_quiet: assert property (
      command_flag |=> (!command_flag && bus_ecc_oe == 28'h0)[*8])
      else $error("gap");
   a_priv_confirm: assert property (s_priv |-> ##[3:4] confirm_line)
      else $error("confirm");
   a_bad_err: assert property (s_rx_bad |-> ##[1:4] err_out)
      else $error("parity error");
   a_bad_drop: assert property (s_rx_bad |=> !cmd_valid)
      else $error("bad command kept");
   a_rx_decode: assert property (
      command_flag_in && (^bus_d_in[38:0])
      |=> cmd_valid && {cmd_code, cmd_addr} == $past(bus_d_in[37:0]))
      else $error("decode");
   a_csr_err: assert property (
      rx_data_cycle && rx_is_csr && rx_cycle_num == 2'h0 && !(^bus_d_in[38:0])
      |-> ##[1:4] err_out)
      else $error("register parity");
endmodule

bind bbcc_codec bbcc_codec_asserts u_asserts (.clk_sys, .rst_n, .node_id, .issue_go,
   .issue_cmd, .issue_addr, .command_flag_in, .bus_d_in, .rx_data_cycle, .rx_is_csr,
   .rx_cycle_num, .command_flag, .confirm_line, .req_out, .bus_d_out, .bus_d_oe,
   .bus_ecc_oe, .err_out, .cmd_valid, .cmd_code, .cmd_addr, .busy);

// >>> verif/bbcc_node_model.sv
/*
 Model of another bus node driving the lines the codec samples.
 Assumes calls start at any time and drive just after a rising edge.
*/
`timescale 1ns/1ps
module bbcc_node_model
   import bbcc_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Bus lines
   output logic command_flag_in,
   output logic [127:0] bus_d_in,
   output logic [27:0] bus_ecc_in,
   // Data cycle marking
   output logic rx_data_cycle,
   output logic rx_is_csr,
   output logic [1:0] rx_cycle_num
);
   initial begin
      {command_flag_in, bus_d_in, bus_ecc_in, rx_data_cycle, rx_is_csr, rx_cycle_num} = '0;
   end
   // Check field per longword
   function automatic logic [27:0] ecc_of(input logic [127:0] d, input logic [1:0] cy);
      logic [27:0] e;
      for (int g = 0; g < 4; g++) begin
         for (int b = 0; b < 7; b++) begin
            e[7 * g + b] = (^(BBCC_MATRIX[b] & {d[32 * g +: 32], cy})) ^ BBCC_CHK_INVERT[b];
         end
      end
      return e;
   endfunction
   // Released lines keep changing
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         command_flag_in <= 1'b0;
         rx_data_cycle <= 1'b0;
         bus_d_in <= ~bus_d_in;
         bus_ecc_in <= ~bus_ecc_in;
      end
   endtask
   // Command cycle, odd parity
   task automatic send_cmd(input logic [2:0] c, input logic [34:0] a, input logic bad);
      @(posedge clk_sys);
      command_flag_in <= 1'b1;
      bus_d_in <= {~bus_d_in[127:39], (~^{c, a}) ^ bad, c, a};
      bus_ecc_in <= ~bus_ecc_in;
   endtask
   // Four data cycles
   task automatic send_data(input logic csr, input logic [127:0] w, input int bad);
      logic [127:0] x;
      for (int i = 0; i < 4; i++) begin
         x = (csr && i > 0) ? ~bus_d_in : w + 128'(i);
         if (csr && i == 0) begin
            x[38] = (~^w[37:0]) ^ (bad == 0);
         end
         @(posedge clk_sys);
         command_flag_in <= 1'b0;
         rx_data_cycle <= 1'b1;
         rx_is_csr <= csr;
         rx_cycle_num <= 2'(i);
         bus_d_in <= x;
         bus_ecc_in <= csr ? ~bus_ecc_in : ecc_of(x, 2'(i)) ^ 28'(i == bad);
      end
   endtask
endmodule

// >>> verif/tb.sv
/*
 Self-checking bench for the bus cycle codec.
 Assumes the node model as far side; the bench grants data slots.
*/
`timescale 1ns/1ps
module tb
   import bbcc_pkg::*;
;
   localparam logic [127:0] BASE = 128'h0F1E2D3C_4B5A6978_8796A5B4_C3D2E1F0;
   logic clk_sys, rst_n, ecc_check_skip, issue_go, tx_valid, tx_ready, data_go, stall_in;
   logic [3:0] node_id, req_out;
   logic [2:0] issue_cmd, cmd_code;
   logic [34:0] issue_addr, cmd_addr;
   logic [127:0] tx_data, bus_d_out, bus_d_oe, bus_d_in;
   logic [27:0] bus_ecc_out, bus_ecc_oe, bus_ecc_in;
   logic command_flag, confirm_line, err_out, command_flag_in, rx_data_cycle, rx_is_csr;
   logic [1:0] rx_cycle_num;
   logic cmd_valid, cmd_private, rx_ecc_error, rx_csr_error, busy, err_q;
   int failures, total_checks, ecc_hits, csr_hits, err_hits, e0, e1;

   bbcc_codec DUT (.clk_sys, .rst_n, .node_id, .ecc_check_skip, .issue_go, .issue_cmd,
      .issue_addr, .tx_data, .tx_valid, .tx_ready, .data_go, .stall_in, .command_flag,
      .confirm_line, .req_out, .bus_d_out, .bus_d_oe, .bus_ecc_out, .bus_ecc_oe, .err_out,
      .command_flag_in, .bus_d_in, .bus_ecc_in, .rx_data_cycle, .rx_is_csr, .rx_cycle_num,
      .cmd_valid, .cmd_code, .cmd_addr, .cmd_private, .rx_ecc_error, .rx_csr_error, .busy);
   bbcc_node_model node (.clk_sys, .command_flag_in, .bus_d_in, .bus_ecc_in,
      .rx_data_cycle, .rx_is_csr, .rx_cycle_num);

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      err_q <= err_out;
      ecc_hits <= ecc_hits + int'(rx_ecc_error === 1'b1);
      csr_hits <= csr_hits + int'(rx_csr_error === 1'b1);
      err_hits <= err_hits + int'(err_out === 1'b1 && err_q !== 1'b1);
   end

   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Command, then a refused second request during the gap
   task automatic issue(input logic [2:0] c, input logic [34:0] a);
      logic seen;
      seen = 1'b0;
      @(posedge clk_sys);
      issue_cmd <= c;
      issue_addr <= a;
      issue_go <= 1'b1;
      data_go <= 1'b1;
      @(posedge clk_sys);
      issue_go <= 1'b0;
      @(negedge clk_sys);
      chk({busy, command_flag, req_out, bus_d_out[38:0]}, {2'h3, node_id, ~^{c, a}, c, a});
      @(posedge clk_sys);
      issue_go <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         @(negedge clk_sys);
         seen |= confirm_line === 1'b1;
         chk(command_flag, 1'b0);
         @(posedge clk_sys);
         issue_go <= 1'b0;
      end
      chk(seen, c == 3'h7);
   endtask
   task automatic wait_oe;
      for (int n = 0; n < 40; n++) begin
         @(negedge clk_sys);
         if (bus_d_oe[0] === 1'b1) break;
      end
   endtask
   task automatic wait_idle;
      for (int n = 0; n < 60 && busy !== 1'b0; n++) @(negedge clk_sys);
      chk(busy, 1'b0);
      @(posedge clk_sys);
      data_go <= 1'b0;
   endtask

   initial begin
      {clk_sys, rst_n, ecc_check_skip, issue_go, tx_valid, data_go, stall_in} = '0;
      {issue_cmd, issue_addr, tx_data, failures, total_checks} = '0;
      {ecc_hits, csr_hits, err_hits, err_q} = '0;
      node_id = 4'hA;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Fill the buffer until it refuses
      for (int k = 0; k < 17; k++) begin
         @(posedge clk_sys);
         tx_valid <= k < 16;
         tx_data <= BASE + 128'(k);
         @(negedge clk_sys);
         chk(tx_ready, k < 16);
      end
      // Four block writes drain it, wrap bit toggling
      for (int t = 0; t < 4; t++) begin
         issue(3'h1, 35'h2468_ACE0 | 35'(t));
         wait_oe();
         for (int i = 0; i < 4; i++) begin
            chk({bus_d_oe, bus_d_out}, {~128'h0, BASE + 128'(4 * t + i)});
            chk({bus_ecc_oe, bus_ecc_out}, {~28'h0, node.ecc_of(BASE + 128'(4 * t + i), 2'(i))});
            @(negedge clk_sys);
         end
         wait_idle();
      end
      chk(tx_ready, 1'b1);
      node_id <= 4'h5;
      for (int c = 0; c < 8; c++) begin
         issue(3'(c), 35'h1_0000_0040);
         wait_idle();
      end
      tx_data <= 128'h2A_5555_1234;
      issue(3'h5, 35'h0_0000_0123);
      wait_oe();
      chk(bus_d_out[38:0], {~^38'h2A_5555_1234, 38'h2A_5555_1234});
      for (int i = 0; i < 3; i++) begin
         @(negedge clk_sys);
         chk({bus_d_oe, bus_ecc_oe}, 156'h0);
      end
      wait_idle();
      // Stall lands on the first register data slot
      issue(3'h5, 35'h0_0000_0124);
      repeat (2) @(posedge clk_sys);
      stall_in <= 1'b1;
      @(posedge clk_sys);
      stall_in <= 1'b0;
      wait_oe();
      chk(bus_d_out[38:0], {^38'h2A_5555_1234, 38'h2A_5555_1234});
      @(negedge clk_sys);
      chk(bus_d_out[38:0], {~^38'h2A_5555_1234, 38'h2A_5555_1234});
      wait_idle();
      // Reset in mid-run
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chk({busy, command_flag, err_out, cmd_valid, tx_ready}, 5'h01);
      // Receive side: every command code decoded
      for (int c = 0; c < 8; c++) begin
         node.send_cmd(3'(c), 35'h1234_5678 ^ 35'(c), 1'b0);
         node.idle(1);
         @(negedge clk_sys);
         chk({cmd_valid, cmd_code, cmd_addr, cmd_private}, {1'b1, 3'(c), 35'h1234_5678 ^ 35'(c), c == 7});
         node.idle(4);
      end
      e0 = err_hits;
      node.send_cmd(3'h1, 35'h0, 1'b1);
      node.idle(1);
      @(negedge clk_sys);
      chk(cmd_valid, 1'b0);
      node.idle(6);
      chk(err_hits - e0, 1);
      // Good, corrupted, corrupted but unchecked memory data
      for (int s = 0; s < 3; s++) begin
         ecc_check_skip <= s == 2;
         e0 = ecc_hits;
         node.send_cmd(3'h1, 35'h40, 1'b0);
         node.idle(10);
         node.send_data(1'b0, BASE, s == 0 ? -1 : 2);
         node.idle(3);
         chk(ecc_hits - e0, s == 1);
      end
      ecc_check_skip <= 1'b0;
      e0 = csr_hits;
      e1 = err_hits;
      node.send_cmd(3'h5, 35'h80, 1'b0);
      node.idle(10);
      node.send_data(1'b1, BASE, 0);
      node.idle(6);
      chk({csr_hits - e0, err_hits - e1}, {32'd1, 32'd1});
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      tally_and_finish();
   end
endmodule
